//--- verilog/hgp_cfg.svh
// constants for the high gpio ports block: sfr offsets, reset values, field positions
// assumes the cpu special-function-register bus presents page, address and strobes
`ifndef HGP_CFG_SVH
`define HGP_CFG_SVH
`define HGP_SFR_PAGE 8'h0f
`define HGP_A_OUT_MODE_ADDR 8'h9c
`define HGP_B_OUT_MODE_ADDR 8'h9d
`define HGP_C_OUT_MODE_ADDR 8'h9e
`define HGP_D_OUT_MODE_ADDR 8'h9f
`define HGP_A_LATCH_ADDR 8'hc8
`define HGP_B_LATCH_ADDR 8'hd8
`define HGP_C_LATCH_ADDR 8'he8
`define HGP_D_LATCH_ADDR 8'hf8
`define HGP_LATCH_RST 8'hff
`define HGP_OUT_MODE_RST 8'h00
`define HGP_A_WR_STROBE_BIT 7
`define HGP_A_RD_STROBE_BIT 6
`define HGP_A_ALE_BIT 5
`define HGP_NUM_PORTS 4
`endif

//--- verilog/hgp_pkg.sv
// types shared by the high gpio ports block
// assumes hgp_cfg.svh is on the include path
package hgp_pkg;
  typedef logic [7:0] hgp_byte_t;
  typedef enum logic [1:0] {
    hgp_port_a,
    hgp_port_b,
    hgp_port_c,
    hgp_port_d
  } hgp_port_e;
  typedef enum logic [1:0] {
    hgp_acc_idle,
    hgp_acc_byte,
    hgp_acc_bit
  } hgp_acc_e;
endpackage

//--- verilog/hgp_sync.sv
// two-flop synchroniser for one port's eight pin levels
// assumes pin levels may change at any time relative to mclk
module hgp_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin levels in, synchronised levels out
  input wire hgp_pkg::hgp_byte_t pin_in,
  output hgp_pkg::hgp_byte_t pin_sync
);
  import hgp_pkg::*;
  hgp_byte_t stage1_ff, stage2_ff;
  hgp_byte_t nxt_stage1, nxt_stage2;

  always_comb begin
    nxt_stage1 = pin_in;
    nxt_stage2 = stage1_ff;
  end

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_ff <= 8'hff;
      stage2_ff <= 8'hff;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign pin_sync = stage2_ff;
endmodule

//--- verilog/hgp_pad.sv
// per-port pad drive logic: latch, mode, memory-interface override, pull-ups
// assumes all inputs are registered in the top; outputs go to flops in the top
module hgp_pad (
  // software state
  input wire hgp_pkg::hgp_byte_t latch,
  input wire hgp_pkg::hgp_byte_t out_mode,
  input wire logic pullup_global_disable,
  // external memory interface claim
  input wire hgp_pkg::hgp_byte_t external_memory_interface_own,
  input wire hgp_pkg::hgp_byte_t external_memory_interface_level,
  input wire hgp_pkg::hgp_byte_t external_memory_interface_float,
  // pad controls
  output hgp_pkg::hgp_byte_t pad_out,
  output hgp_pkg::hgp_byte_t pad_oe_n,
  output hgp_pkg::hgp_byte_t pad_pullup_en
);
  import hgp_pkg::*;
  hgp_byte_t level;
  hgp_byte_t drive_low;

  always_comb begin
    // memory interface owns the level, latch ignored
    level = (external_memory_interface_own & external_memory_interface_level) | (~external_memory_interface_own & latch);
    // push-pull drives both levels, open-drain only low
    pad_out = level;
    pad_oe_n = ~(out_mode | ~level);
    // external read floats the data bus drivers; mode bits left untouched
    pad_oe_n = pad_oe_n | (external_memory_interface_own & external_memory_interface_float);
    drive_low = ~pad_oe_n & ~level;
    // pull-up off when globally disabled or pin driven low
    pad_pullup_en = {8{~pullup_global_disable}} & ~drive_low;
  end
endmodule

//--- verilog/hgp_top.sv
// high gpio ports four to seven: sfr latches, output modes, pin reads, pad drive
// assumes a single-cycle sfr bus on mclk with page select, bit access and rmw flag;
// the memory interface presents per-pin ownership while a external_move_instruction executes
`include "hgp_cfg.svh"

module hgp_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sfr bus
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_acc,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_rmw,
  input wire hgp_pkg::hgp_byte_t sfr_wdata,
  output hgp_pkg::hgp_byte_t sfr_rdata,
  output logic sfr_hit,
  // global pull-up disable from crossbar config two
  input wire logic pullup_global_disable,
  // external memory interface
  input wire logic external_memory_interface_high_sel,
  input wire logic external_memory_interface_active,
  input wire logic external_memory_interface_muxed,
  input wire logic external_memory_interface_read,
  input wire logic external_memory_interface_wr_n,
  input wire logic external_memory_interface_rd_n,
  input wire logic external_memory_interface_ale,
  input wire logic [15:0] external_memory_interface_addr,
  input wire hgp_pkg::hgp_byte_t external_memory_interface_wdata,
  // pads, four ports of eight
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe_n,
  output logic [31:0] pad_pullup_en
);
  import hgp_pkg::*;

  hgp_byte_t latch_ff [`HGP_NUM_PORTS];
  hgp_byte_t nxt_latch [`HGP_NUM_PORTS];
  hgp_byte_t mode_ff [`HGP_NUM_PORTS];
  hgp_byte_t nxt_mode [`HGP_NUM_PORTS];
  hgp_byte_t pin_sync [`HGP_NUM_PORTS];
  hgp_byte_t rdata_ff, nxt_rdata;
  logic hit_ff, nxt_hit;
  logic pud_ff, nxt_pud;
  hgp_byte_t own_ff [`HGP_NUM_PORTS];
  hgp_byte_t lvl_ff [`HGP_NUM_PORTS];
  hgp_byte_t flt_ff [`HGP_NUM_PORTS];
  hgp_byte_t nxt_own [`HGP_NUM_PORTS];
  hgp_byte_t nxt_lvl [`HGP_NUM_PORTS];
  hgp_byte_t nxt_flt [`HGP_NUM_PORTS];
  logic [31:0] pad_out_ff, pad_oe_n_ff, pad_pu_ff;
  logic [31:0] nxt_pad_out, nxt_pad_oe_n, nxt_pad_pu;
  logic page_ok;
  logic [1:0] lat_idx, mode_idx;
  logic lat_hit, mode_hit;
  hgp_byte_t rd_src, wr_val;
  logic external_memory_interface_on;

  // pins synchronised before any read, bonded or not
  genvar g;
  generate
    for (g = 0; g < `HGP_NUM_PORTS; g++) begin : g_port
      hgp_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in(pad_in[g*8 +: 8]),
        .pin_sync(pin_sync[g])
      );
      hgp_pad u_pad (
        .latch(latch_ff[g]),
        .out_mode(mode_ff[g]),
        .pullup_global_disable(pud_ff),
        .external_memory_interface_own(own_ff[g]),
        .external_memory_interface_level(lvl_ff[g]),
        .external_memory_interface_float(flt_ff[g]),
        .pad_out(nxt_pad_out[g*8 +: 8]),
        .pad_oe_n(nxt_pad_oe_n[g*8 +: 8]),
        .pad_pullup_en(nxt_pad_pu[g*8 +: 8])
      );
    end
  endgenerate

  // address decode, all on page f
  always_comb begin
    page_ok = (sfr_page == `HGP_SFR_PAGE);
    lat_hit = 1'b1;
    lat_idx = 2'd0;
    case (sfr_addr)
      `HGP_A_LATCH_ADDR: lat_idx = 2'd0;
      `HGP_B_LATCH_ADDR: lat_idx = 2'd1;
      `HGP_C_LATCH_ADDR: lat_idx = 2'd2;
      `HGP_D_LATCH_ADDR: lat_idx = 2'd3;
      default: lat_hit = 1'b0;
    endcase
    mode_hit = 1'b1;
    mode_idx = 2'd0;
    case (sfr_addr)
      `HGP_A_OUT_MODE_ADDR: mode_idx = 2'd0;
      `HGP_B_OUT_MODE_ADDR: mode_idx = 2'd1;
      `HGP_C_OUT_MODE_ADDR: mode_idx = 2'd2;
      `HGP_D_OUT_MODE_ADDR: mode_idx = 2'd3;
      default: mode_hit = 1'b0;
    endcase
    lat_hit = lat_hit & page_ok;
    mode_hit = mode_hit & page_ok;
  end

  // register writes and read data
  always_comb begin
    for (int i = 0; i < `HGP_NUM_PORTS; i++) begin
      nxt_latch[i] = latch_ff[i];
      nxt_mode[i] = mode_ff[i];
    end
    // rmw reads the latch, plain reads the pins
    rd_src = sfr_rmw ? latch_ff[lat_idx] : pin_sync[lat_idx];
    if (!lat_hit) begin
      rd_src = mode_ff[mode_idx];
    end
    wr_val = sfr_wdata;
    if (sfr_bit_acc) begin
      // bit write merges into the latch, not the pins
      wr_val = latch_ff[lat_idx];
      wr_val[sfr_bit_sel] = sfr_wdata[0];
    end
    if (sfr_wr && lat_hit) begin
      nxt_latch[lat_idx] = wr_val;
    end
    if (sfr_wr && mode_hit) begin
      nxt_mode[mode_idx] = sfr_wdata;
    end
    nxt_hit = sfr_rd && (lat_hit || mode_hit);
    nxt_rdata = 8'h00;
    if (nxt_hit) begin
      nxt_rdata = (sfr_bit_acc && lat_hit) ? {7'h00, rd_src[sfr_bit_sel]} : rd_src;
    end
    nxt_pud = pullup_global_disable;
  end

  // memory interface pin ownership per port
  always_comb begin
    for (int i = 0; i < `HGP_NUM_PORTS; i++) begin
      nxt_own[i] = 8'h00;
      nxt_lvl[i] = 8'h00;
      nxt_flt[i] = 8'h00;
    end
    if (external_memory_interface_high_sel && external_memory_interface_active) begin
      nxt_own[0] = 8'he0;
      nxt_lvl[0] = {external_memory_interface_wr_n, external_memory_interface_rd_n, external_memory_interface_ale, 5'h00};
      nxt_own[2] = 8'hff;
      nxt_lvl[2] = external_memory_interface_muxed ? external_memory_interface_addr[15:8] : external_memory_interface_addr[7:0];
      nxt_own[3] = 8'hff;
      nxt_lvl[3] = (external_memory_interface_muxed && external_memory_interface_ale) ? external_memory_interface_addr[7:0] : external_memory_interface_wdata;
      if (!external_memory_interface_muxed) begin
        nxt_own[1] = 8'hff;
        nxt_lvl[1] = external_memory_interface_addr[15:8];
      end
      // data bus floats on reads, but not during the address phase
      if (external_memory_interface_read && !(external_memory_interface_muxed && external_memory_interface_ale)) begin
        nxt_flt[3] = 8'hff;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `HGP_NUM_PORTS; i++) begin
        latch_ff[i] <= `HGP_LATCH_RST;
        mode_ff[i] <= `HGP_OUT_MODE_RST;
        own_ff[i] <= 8'h00;
        lvl_ff[i] <= 8'h00;
        flt_ff[i] <= 8'h00;
      end
      rdata_ff <= 8'h00;
      hit_ff <= 1'b0;
      pud_ff <= 1'b0;
      pad_out_ff <= 32'hffffffff;
      pad_oe_n_ff <= 32'hffffffff;
      pad_pu_ff <= 32'hffffffff;
    end else begin
      for (int i = 0; i < `HGP_NUM_PORTS; i++) begin
        latch_ff[i] <= nxt_latch[i];
        mode_ff[i] <= nxt_mode[i];
        own_ff[i] <= nxt_own[i];
        lvl_ff[i] <= nxt_lvl[i];
        flt_ff[i] <= nxt_flt[i];
      end
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      pud_ff <= nxt_pud;
      pad_out_ff <= nxt_pad_out;
      pad_oe_n_ff <= nxt_pad_oe_n;
      pad_pu_ff <= nxt_pad_pu;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign sfr_hit = hit_ff;
  assign pad_out = pad_out_ff;
  assign pad_oe_n = pad_oe_n_ff;
  assign pad_pullup_en = pad_pu_ff;
  assign external_memory_interface_on = external_memory_interface_high_sel && external_memory_interface_active;

  a_mode_reset: assert property (@(posedge mclk)
    $fell(rst) |-> mode_ff[0] == 8'h00 && mode_ff[3] == 8'h00)
    else $error("mode register not cleared by reset");
  a_latch_reset: assert property (@(posedge mclk)
    $fell(rst) |-> latch_ff[1] == 8'hff && latch_ff[2] == 8'hff)
    else $error("latch not all ones after reset");
  a_od_high_float: assert property (@(posedge mclk) disable iff (rst)
    (mode_ff[0][0] == 1'b0 && latch_ff[0][0] && own_ff[0] == 8'h00) |=> pad_oe_n[0])
    else $error("open-drain high pin is driven");
  a_pp_drive: assert property (@(posedge mclk) disable iff (rst)
    (mode_ff[1][1] && own_ff[1] == 8'h00) |=> !pad_oe_n[9] && pad_out[9] == $past(latch_ff[1][1]))
    else $error("push-pull pin not driven from latch");
  a_low_drive: assert property (@(posedge mclk) disable iff (rst)
    (latch_ff[2][0] == 1'b0 && own_ff[2] == 8'h00) |=> !pad_oe_n[16] && !pad_out[16])
    else $error("latch zero does not drive low");
  a_pullup_off: assert property (@(posedge mclk) disable iff (rst)
    (!pad_oe_n[5] && !pad_out[5]) |-> !pad_pullup_en[5])
    else $error("pull-up on while driving low");
  a_pullup_global: assert property (@(posedge mclk) disable iff (rst)
    pullup_global_disable[*2] |=> pad_pullup_en == 32'h0)
    else $error("pull-up on while globally disabled");
  a_pin_read: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && !sfr_rmw && !sfr_bit_acc && page_ok && sfr_addr == `HGP_C_LATCH_ADDR)
    |=> sfr_rdata == $past(pin_sync[2]) && sfr_hit)
    else $error("plain read does not return pins");
  a_rmw_read: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && sfr_rmw && !sfr_bit_acc && page_ok && sfr_addr == `HGP_D_LATCH_ADDR)
    |=> sfr_rdata == $past(latch_ff[3]))
    else $error("rmw read does not return latch");
  a_external_memory_interface_read_float: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_high_sel && external_memory_interface_active && external_memory_interface_read && !external_memory_interface_muxed) |=> ##1 pad_oe_n[31:24] == 8'hff)
    else $error("data bus driven during external read");
  a_external_memory_interface_addr: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_on && !external_memory_interface_muxed) |=> ##1 pad_out[15:8] == $past(external_memory_interface_addr[15:8], 2))
    else $error("address high not on second port");
  // memory interface inputs reach the pads two edges later
  a_external_memory_interface_strobes: assert property (@(posedge mclk) disable iff (rst)
    external_memory_interface_on |=> ##1 pad_out[7:5] == $past({external_memory_interface_wr_n, external_memory_interface_rd_n, external_memory_interface_ale}, 2))
    else $error("strobes not on first port");
  a_external_memory_interface_mux_hi: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_on && external_memory_interface_muxed) |=> ##1 pad_out[23:16] == $past(external_memory_interface_addr[15:8], 2))
    else $error("muxed address high not on third port");
  a_external_memory_interface_lo: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_on && !external_memory_interface_muxed) |=> ##1 pad_out[23:16] == $past(external_memory_interface_addr[7:0], 2))
    else $error("address low not on third port");
  a_external_memory_interface_data: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_on && !external_memory_interface_muxed) |=> ##1 pad_out[31:24] == $past(external_memory_interface_wdata, 2))
    else $error("data not on fourth port");
  a_external_memory_interface_ad: assert property (@(posedge mclk) disable iff (rst)
    (external_memory_interface_on && external_memory_interface_muxed && external_memory_interface_ale) |=> ##1 pad_out[31:24] == $past(external_memory_interface_addr[7:0], 2))
    else $error("address low not on fourth port in muxed mode");
  // register bus side, answer one edge after the strobe
  a_mode_write: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && page_ok && sfr_addr == `HGP_B_OUT_MODE_ADDR)
    |=> mode_ff[1] == $past(sfr_wdata))
    else $error("mode register write lost");
  a_latch_write: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && !sfr_bit_acc && page_ok && sfr_addr == `HGP_A_LATCH_ADDR)
    |=> latch_ff[0] == $past(sfr_wdata))
    else $error("latch byte write lost");
  a_bit_write: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && sfr_bit_acc && sfr_bit_sel == 3'h3 && page_ok && sfr_addr == `HGP_B_LATCH_ADDR)
    |=> latch_ff[1][3] == $past(sfr_wdata[0]))
    else $error("latch bit write lost");
  a_rmw_bit: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && sfr_rmw && sfr_bit_acc && page_ok && sfr_addr == `HGP_B_LATCH_ADDR)
    |=> sfr_rdata == {7'h00, $past(latch_ff[1][sfr_bit_sel])})
    else $error("rmw bit read does not return latch bit");
  a_mode_read: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && page_ok && sfr_addr == `HGP_D_OUT_MODE_ADDR)
    |=> sfr_hit && sfr_rdata == $past(mode_ff[3]))
    else $error("mode register read wrong");
  a_other_page: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && !page_ok) |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read answered on another page");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read data stands without a read");

  c_bit_write: cover property (@(posedge mclk) sfr_wr && sfr_bit_acc && lat_hit);
  c_rmw_read: cover property (@(posedge mclk) sfr_rd && sfr_rmw && lat_hit);
  c_external_memory_interface_muxed: cover property (@(posedge mclk) external_memory_interface_high_sel && external_memory_interface_active && external_memory_interface_muxed);
  c_mode_write: cover property (@(posedge mclk) sfr_wr && mode_hit);
  c_external_memory_interface_read: cover property (@(posedge mclk) external_memory_interface_on && external_memory_interface_read);
endmodule

//--- test/hgp_pins.sv
// board side of the high ports: resolves each wire from every driver on it
// assumes pad controls come straight from hgp_top, one bit per pin
module hgp_pins (
  // clock
  input wire logic mclk,
  // pad controls from the block
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pad_pullup_en,
  // board drivers, only used on pins the block leaves open
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  // resolved wire levels
  output logic [31:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] drift_ff = 32'h5555_5555;
  // an open, unpulled pin wanders, so its last value is never trusted
  always @(posedge mclk) drift_ff <= ~drift_ff;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = drift_ff[i];
    end
  end
endmodule

//--- test/hgp_top_tb.sv
// self-checking bench for the high ports: sfr accesses, pad drive, memory takeover
// assumes hgp_pins resolves the wires and the sfr bus takes one request per cycle
`include "hgp_cfg.svh"
module hgp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hgp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_page = `HGP_SFR_PAGE;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_acc = 1'b0, sfr_rmw = 1'b0, sfr_hit, pud = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  hgp_byte_t sfr_wdata = 8'h00, sfr_rdata, rd_d, l, m;
  logic e_sel = 1'b0, e_act = 1'b0, e_mux = 1'b0, e_rd = 1'b0, e_wrn = 1'b1, e_rdn = 1'b1;
  logic e_ale = 1'b0, rd_h;
  logic [15:0] e_addr = 16'h1234;
  hgp_byte_t e_wd = 8'h9c;
  logic [31:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, ext_en = 32'h0, ext_val = 32'h0;
  logic [7:0] lat [4] = '{`HGP_A_LATCH_ADDR, `HGP_B_LATCH_ADDR, `HGP_C_LATCH_ADDR,
    `HGP_D_LATCH_ADDR};
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  hgp_top i_hgp_top (.mclk(mclk), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_acc(sfr_bit_acc), .sfr_bit_sel(sfr_bit_sel),
    .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .pullup_global_disable(pud), .external_memory_interface_high_sel(e_sel), .external_memory_interface_active(e_act),
    .external_memory_interface_muxed(e_mux), .external_memory_interface_read(e_rd), .external_memory_interface_wr_n(e_wrn), .external_memory_interface_rd_n(e_rdn),
    .external_memory_interface_ale(e_ale), .external_memory_interface_addr(e_addr), .external_memory_interface_wdata(e_wd), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en));
  hgp_pins i_hgp_pins (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input hgp_byte_t d, input logic bt, input logic [2:0] s);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_bit_acc <= bt;
    sfr_bit_sel <= s;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask
  // read data stands for one cycle only, so it is taken right after the answering edge
  task automatic rd(input logic [7:0] a, input logic rmw, input logic bt, input logic [2:0] s);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rmw <= rmw;
    sfr_bit_acc <= bt;
    sfr_bit_sel <= s;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1;
    rd_d = sfr_rdata;
    rd_h = sfr_hit;
  endtask
  task automatic external_memory_interface(input logic act, mux, rdc, wrn, rdn, ale);
    @(posedge mclk);
    e_sel <= 1'b1;
    e_act <= act;
    e_mux <= mux;
    e_rd <= rdc;
    e_wrn <= wrn;
    e_rdn <= rdn;
    e_ale <= ale;
    settle(3);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    settle(1);
    chk("oe_n reset", 32'hffff_ffff, pad_oe_n);
    chk("pullup reset", 32'hffff_ffff, pad_pullup_en);
    for (int p = 0; p < 4; p++) begin
      rd(`HGP_A_OUT_MODE_ADDR + 8'(p), 1'b0, 1'b0, 3'h0);
      chk("mode reset", {24'h0, `HGP_OUT_MODE_RST}, {24'h0, rd_d});
      rd(lat[p], 1'b1, 1'b0, 3'h0);
      chk("latch reset", 32'hff, {24'h0, rd_d});
      chk("hit", 32'h1, {31'h0, rd_h});
      wr(lat[p], 8'h3c ^ 8'(p), 1'b0, 3'h0);
      wr(`HGP_A_OUT_MODE_ADDR + 8'(p), 8'h81 << p, 1'b0, 3'h0);
    end
    settle(2);
    for (int p = 0; p < 4; p++) begin
      l = 8'h3c ^ 8'(p);
      m = 8'h81 << p;
      chk("pad_out", {24'h0, l}, {24'h0, pad_out[8*p+:8]});
      chk("pad_oe_n", {24'h0, l & ~m}, {24'h0, pad_oe_n[8*p+:8]});
      chk("pullup", {24'h0, l}, {24'h0, pad_pullup_en[8*p+:8]});
      rd(`HGP_A_OUT_MODE_ADDR + 8'(p), 1'b0, 1'b0, 3'h0);
      chk("mode", {24'h0, m}, {24'h0, rd_d});
    end
    // the board pulls every open pin of port a low; only those pins may change
    ext_en[7:0] <= 8'h3c;
    settle(4);
    rd(lat[0], 1'b0, 1'b0, 3'h0);
    chk("pin read", 32'h0, {24'h0, rd_d});
    rd(lat[0], 1'b1, 1'b0, 3'h0);
    chk("rmw read", 32'h3c, {24'h0, rd_d});
    ext_en <= 32'h0;
    pud <= 1'b1;
    settle(3);
    chk("pullup off", 32'h0, pad_pullup_en);
    pud <= 1'b0;
    wr(lat[1], 8'h00, 1'b1, 3'h3);
    rd(lat[1], 1'b1, 1'b1, 3'h3);
    chk("bit 3", 32'h0, {24'h0, rd_d});
    rd(lat[1], 1'b1, 1'b1, 3'h2);
    chk("bit 2", 32'h1, {24'h0, rd_d});
    rd(lat[1], 1'b1, 1'b0, 3'h0);
    chk("latch b", 32'h35, {24'h0, rd_d});
    // port c: open pins pulled up, push-pull bit 2 high, the rest driven low
    rd(lat[2], 1'b0, 1'b0, 3'h0);
    chk("pin read c", 32'h3e, {24'h0, rd_d});
    sfr_page <= 8'h00;
    wr(lat[0], 8'h00, 1'b0, 3'h0);
    rd(lat[0], 1'b1, 1'b0, 3'h0);
    chk("other page", 32'h0, {23'h0, rd_h, rd_d});
    sfr_page <= `HGP_SFR_PAGE;
    rd(lat[0], 1'b1, 1'b0, 3'h0);
    chk("kept latch", 32'h13c, {23'h0, rd_h, rd_d});
    rd(8'h9b, 1'b0, 1'b0, 3'h0);
    chk("unmapped", 32'h0, {23'h0, rd_h, rd_d});
    wr(`HGP_D_OUT_MODE_ADDR, 8'hff, 1'b0, 3'h0);
    // the low-port memory enable is not part of this block and stays off
    external_memory_interface(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("strobes", 32'h2, {29'h0, pad_out[7:5]});
    chk("nonmux", 32'h9c_34_12, {8'h0, pad_out[31:8]});
    chk("data drive", 32'h0, {24'h0, pad_oe_n[31:24]});
    external_memory_interface(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    chk("muxed", 32'h3412, {16'h0, pad_out[31:16]});
    external_memory_interface(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("read float", 32'hff, {24'h0, pad_oe_n[31:24]});
    external_memory_interface(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("latch back", 32'h35, {24'h0, pad_out[15:8]});
    rd(`HGP_D_OUT_MODE_ADDR, 1'b0, 1'b0, 3'h0);
    chk("mode kept", 32'hff, {24'h0, rd_d});
    tally_and_finish();
  end
endmodule
